// ===== rtl/uvp_pkg.sv
// Package of constants and types for the undervoltage protection element
package uvp_pkg;
   // Register byte offsets
   localparam logic [7:0] UVP_CTRL_OFS = 8'h00;
   localparam logic [7:0] UVP_ALM_PU_OFS = 8'h04;
   localparam logic [7:0] UVP_TRP_PU_OFS = 8'h08;
   localparam logic [7:0] UVP_DELAY_OFS = 8'h0C;
   localparam logic [7:0] UVP_STATUS_OFS = 8'h10;
   localparam logic [7:0] UVP_IRQ_STAT_OFS = 8'h14;
   localparam logic [7:0] UVP_IRQ_MASK_OFS = 8'h18;
   localparam logic [7:0] UVP_RESET_OFS = 8'h1C;

   // Control register fields
   localparam int UVP_ALM_MODE_POS = 0;
   localparam int UVP_TRP_MODE_POS = 2;
   localparam int UVP_ALM_RLY_POS = 4;
   localparam int UVP_TRP_RLY_POS = 8;
   localparam int UVP_ACT_STOP_POS = 12;
   localparam int UVP_ALM_EVT_POS = 13;
   localparam int UVP_VT_WIRE_POS = 14;
   // Pickup register fields: starting low, running high
   localparam int UVP_PU_START_POS = 0;
   localparam int UVP_PU_RUN_POS = 8;
   // Delay register fields: alarm low, trip high
   localparam int UVP_DLY_ALM_POS = 0;
   localparam int UVP_DLY_TRP_POS = 16;
   // Interrupt status bits
   localparam int UVP_IRQ_ALM_POS = 0;
   localparam int UVP_IRQ_TRP_POS = 1;
   localparam int UVP_IRQ_LOG_POS = 2;
   localparam int UVP_IRQ_W = 3;

   // Settings ranges in hundredths and tenths
   localparam logic [6:0] UVP_PU_MIN = 7'd50;
   localparam logic [6:0] UVP_PU_MAX = 7'd99;
   localparam logic [6:0] UVP_PU_SCALE = 7'd100;
   localparam logic [11:0] UVP_DLY_MAX = 12'd2550;

   // Reset values
   localparam logic [6:0] UVP_ALM_PU_RST = 7'd85;
   localparam logic [6:0] UVP_TRP_PU_RST = 7'd80;
   localparam logic [11:0] UVP_ALM_DLY_RST = 12'd30;
   localparam logic [11:0] UVP_TRP_DLY_RST = 12'd10;
   localparam logic [2:0] UVP_ALM_RLY_RST = 3'h1;
   localparam logic [2:0] UVP_TRP_RLY_RST = 3'h1;

   // Delay step timing
   localparam longint UVP_STEP_NS = 100_000_000;
   localparam longint UVP_CLK_NS = 8;
   localparam int UVP_STEP_CYCLES = int'(UVP_STEP_NS / UVP_CLK_NS);

   typedef enum logic [1:0]
   {
      UVP_MODE_OFF = 2'b00,
      UVP_MODE_LATCHED = 2'b01,
      UVP_MODE_UNLATCHED = 2'b10
   } uvp_mode_e;

   typedef enum logic [1:0]
   {
      UVP_VT_NONE = 2'b00,
      UVP_VT_WYE = 2'b01,
      UVP_VT_DELTA = 2'b10
   } uvp_vt_e;

   typedef enum logic [1:0]
   {
      UVP_MOT_STOPPED = 2'b00,
      UVP_MOT_STARTING = 2'b01,
      UVP_MOT_RUNNING = 2'b10
   } uvp_motor_e;

   // Line-to-line voltage magnitudes, same unit as rated voltage
   typedef struct packed
   {
      logic [15:0] vab;
      logic [15:0] vbc;
      logic [15:0] vca;
   } uvp_volt_s;

   // Output relay bundle
   typedef struct packed
   {
      logic alarm_relay;
      logic trip_relay;
      logic auxiliary_relay_one;
      logic auxiliary_relay_two;
   } uvp_relay_s;
endpackage : uvp_pkg

// ===== rtl/uvp_delay_timer.sv
// Pickup delay timer counting 0.1 s steps while the condition holds
`timescale 1ns/1ps
module uvp_delay_timer
   import uvp_pkg::*;
#(
   parameter int DLY_W = 12
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cond,
   input wire logic step,
   input wire logic [DLY_W-1:0] delay,
   output logic operate
);
   logic [DLY_W-1:0] cnt_ff;
   logic [DLY_W-1:0] nxt_cnt;

   always_comb
   begin
      nxt_cnt = cnt_ff;
      if (!cond)
      begin
         nxt_cnt = '0; // R17
      end
      else if (step && (cnt_ff < delay))
      begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_ff <= '0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign operate = cond && (cnt_ff >= delay); // R9
endmodule : uvp_delay_timer

// ===== rtl/uvp_top.sv
// Undervoltage protection element with APB settings and relay outputs
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
// What this block does
// R1: Alarm and trip each have mode off, latched or unlatched; off disables.
// R2: Alarm drives any mix of alarm, auxiliary one and auxiliary two relays.
// R3: Trip drives any mix of trip, auxiliary one and auxiliary two relays.
// R4: All four pickups settable 0.50 to 0.99 of rated in 0.01 steps.
// R5: Starting and running alarm pickups reset to 0.85 of rated.
// R6: Alarm and trip delays settable 0.0 to 255.0 s in 0.1 s steps.
// R7: Alarm delay resets to 3.0 s.
// R8: Alarm event logging is an on/off setting, off at reset.
// R9: Operate when any line voltage stays below the state's pickup for the delay.
// R10: Alarm and trip use separate pickups and separate timers.
// R11: Pickups are multiples of the rated nameplate voltage.
// R12: Setting no blocks the element while stopped; yes keeps it active.
// R13: Stopped means no phase current and starter reports open.
// R14: With active-while-stopped yes, a trip holds while voltage stays absent.
// R15: Element inactive unless voltage option fitted and wiring is not none.
// R16: Use line-to-line voltages whatever the transformer wiring.
// R17: A timer restarts from zero when all voltages recover first.
// R18: Latched output holds until reset; unlatched drops when condition clears.
module uvp_top
   import uvp_pkg::*;
#(
   parameter int STEP_CYCLES = UVP_STEP_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire uvp_volt_s line_volts,
   input wire logic [15:0] rated_voltage,
   input wire logic phase_current_present,
   input wire logic starter_closed,
   input wire logic motor_starting,
   input wire logic voltage_option_fitted,
   output uvp_relay_s relays,
   output logic event_log_strobe,
   output logic irq
);
   // Settings
   uvp_mode_e alm_mode_ff;
   uvp_mode_e trp_mode_ff;
   logic [2:0] alm_rly_ff;
   logic [2:0] trp_rly_ff;
   logic act_stop_ff;
   logic alm_evt_ff;
   uvp_vt_e vt_wire_ff;
   logic [6:0] alm_pu_start_ff;
   logic [6:0] alm_pu_run_ff;
   logic [6:0] trp_pu_start_ff;
   logic [6:0] trp_pu_run_ff;
   logic [11:0] alm_dly_ff;
   logic [11:0] trp_dly_ff;
   logic [UVP_IRQ_W-1:0] irq_stat_ff;
   logic [UVP_IRQ_W-1:0] irq_mask_ff;
   logic [31:0] prdata_ff;

   // Engine state
   logic [31:0] step_cnt_ff;
   logic step_ff;
   logic alm_latch_ff;
   logic trp_latch_ff;
   logic alm_prev_ff;
   logic trp_prev_ff;
   logic log_ff;
   uvp_relay_s relays_ff;

   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic reset_cmd;
   uvp_motor_e motor_state;
   logic element_on;
   logic [6:0] alm_pu;
   logic [6:0] trp_pu;
   logic alm_below;
   logic trp_below;
   logic alm_op;
   logic trp_op;
   logic alm_out;
   logic trp_out;
   logic [UVP_IRQ_W-1:0] irq_evt;

   function automatic logic [6:0] clamp_pu(input logic [6:0] v);
      if (v < UVP_PU_MIN)
      begin
         return UVP_PU_MIN;
      end
      else if (v > UVP_PU_MAX)
      begin
         return UVP_PU_MAX;
      end
      return v;
   endfunction : clamp_pu

   function automatic logic [11:0] clamp_dly(input logic [11:0] v);
      return (v > UVP_DLY_MAX) ? UVP_DLY_MAX : v;
   endfunction : clamp_dly

   function automatic uvp_mode_e dec_mode(input logic [1:0] v);
      case (v)
         2'b01: return UVP_MODE_LATCHED;
         2'b10: return UVP_MODE_UNLATCHED;
         default: return UVP_MODE_OFF;
      endcase
   endfunction : dec_mode

   // Any one line voltage below pickup times rated
   function automatic logic any_below(input uvp_volt_s v, input logic [6:0] pu,
                                      input logic [15:0] rated);
      logic [23:0] lim;
      lim = 24'(pu) * 24'(rated); // R11
      return ((24'(v.vab) * 24'(UVP_PU_SCALE)) < lim) || // R16
             ((24'(v.vbc) * 24'(UVP_PU_SCALE)) < lim) ||
             ((24'(v.vca) * 24'(UVP_PU_SCALE)) < lim); // R9
   endfunction : any_below

   function automatic logic mode_output(input uvp_mode_e m, input logic op,
                                        input logic latched);
      case (m)
         UVP_MODE_LATCHED: return op || latched; // R18
         UVP_MODE_UNLATCHED: return op; // R18
         default: return 1'b0; // R1
      endcase
   endfunction : mode_output

   // APB decode
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= UVP_RESET_OFS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_ff;
   assign reset_cmd = wr_en && (paddr == UVP_RESET_OFS) && pwdata[0];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alm_mode_ff <= UVP_MODE_OFF;
         trp_mode_ff <= UVP_MODE_OFF;
         alm_rly_ff <= UVP_ALM_RLY_RST;
         trp_rly_ff <= UVP_TRP_RLY_RST;
         act_stop_ff <= 1'b0;
         alm_evt_ff <= 1'b0; // R8
         vt_wire_ff <= UVP_VT_NONE;
      end
      else if (wr_en && (paddr == UVP_CTRL_OFS))
      begin
         alm_mode_ff <= dec_mode(pwdata[UVP_ALM_MODE_POS +: 2]); // R1
         trp_mode_ff <= dec_mode(pwdata[UVP_TRP_MODE_POS +: 2]); // R1
         alm_rly_ff <= pwdata[UVP_ALM_RLY_POS +: 3]; // R2
         trp_rly_ff <= pwdata[UVP_TRP_RLY_POS +: 3]; // R3
         act_stop_ff <= pwdata[UVP_ACT_STOP_POS];
         alm_evt_ff <= pwdata[UVP_ALM_EVT_POS]; // R8
         case (pwdata[UVP_VT_WIRE_POS +: 2])
            2'b01: vt_wire_ff <= UVP_VT_WYE;
            2'b10: vt_wire_ff <= UVP_VT_DELTA;
            default: vt_wire_ff <= UVP_VT_NONE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alm_pu_start_ff <= UVP_ALM_PU_RST; // R5
         alm_pu_run_ff <= UVP_ALM_PU_RST; // R5
         trp_pu_start_ff <= UVP_TRP_PU_RST;
         trp_pu_run_ff <= UVP_TRP_PU_RST;
         alm_dly_ff <= UVP_ALM_DLY_RST; // R7
         trp_dly_ff <= UVP_TRP_DLY_RST;
      end
      else if (wr_en)
      begin
         if (paddr == UVP_ALM_PU_OFS)
         begin
            alm_pu_start_ff <= clamp_pu(pwdata[UVP_PU_START_POS +: 7]); // R4
            alm_pu_run_ff <= clamp_pu(pwdata[UVP_PU_RUN_POS +: 7]); // R4
         end
         if (paddr == UVP_TRP_PU_OFS)
         begin
            trp_pu_start_ff <= clamp_pu(pwdata[UVP_PU_START_POS +: 7]); // R4
            trp_pu_run_ff <= clamp_pu(pwdata[UVP_PU_RUN_POS +: 7]); // R4
         end
         if (paddr == UVP_DELAY_OFS)
         begin
            alm_dly_ff <= clamp_dly(pwdata[UVP_DLY_ALM_POS +: 12]); // R6
            trp_dly_ff <= clamp_dly(pwdata[UVP_DLY_TRP_POS +: 12]); // R6
         end
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff <= 32'h0;
      end
      else if (rd_setup)
      begin
         case (paddr)
            UVP_CTRL_OFS: prdata_ff <= 32'({vt_wire_ff, alm_evt_ff, act_stop_ff, 1'b0, trp_rly_ff,
                                            1'b0, alm_rly_ff, trp_mode_ff, alm_mode_ff});
            UVP_ALM_PU_OFS: prdata_ff <= 32'({1'b0, alm_pu_run_ff, 1'b0, alm_pu_start_ff});
            UVP_TRP_PU_OFS: prdata_ff <= 32'({1'b0, trp_pu_run_ff, 1'b0, trp_pu_start_ff});
            UVP_DELAY_OFS: prdata_ff <= 32'({4'h0, trp_dly_ff, 4'h0, alm_dly_ff});
            UVP_STATUS_OFS: prdata_ff <= 32'({motor_state, element_on, trp_latch_ff,
                                              alm_latch_ff, trp_op, alm_op});
            UVP_IRQ_STAT_OFS: prdata_ff <= 32'(irq_stat_ff);
            UVP_IRQ_MASK_OFS: prdata_ff <= 32'(irq_mask_ff);
            default: prdata_ff <= 32'h0;
         endcase
      end
   end

   // Motor state and element enable
   always_comb
   begin
      if (!phase_current_present && !starter_closed)
      begin
         motor_state = UVP_MOT_STOPPED; // R13
      end
      else if (motor_starting)
      begin
         motor_state = UVP_MOT_STARTING;
      end
      else
      begin
         motor_state = UVP_MOT_RUNNING;
      end
   end

   assign element_on = voltage_option_fitted && (vt_wire_ff != UVP_VT_NONE) && // R15
                       ((motor_state != UVP_MOT_STOPPED) || act_stop_ff); // R12 R14

   assign alm_pu = (motor_state == UVP_MOT_STARTING) ? alm_pu_start_ff : alm_pu_run_ff; // R9
   assign trp_pu = (motor_state == UVP_MOT_STARTING) ? trp_pu_start_ff : trp_pu_run_ff; // R9
   assign alm_below = element_on && (alm_mode_ff != UVP_MODE_OFF) &&
                      any_below(line_volts, alm_pu, rated_voltage); // R10
   assign trp_below = element_on && (trp_mode_ff != UVP_MODE_OFF) &&
                      any_below(line_volts, trp_pu, rated_voltage); // R10

   // Delay step prescaler
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         step_cnt_ff <= 32'h0;
         step_ff <= 1'b0;
      end
      else if (step_cnt_ff >= 32'(STEP_CYCLES - 1))
      begin
         step_cnt_ff <= 32'h0;
         step_ff <= 1'b1;
      end
      else
      begin
         step_cnt_ff <= step_cnt_ff + 32'h1;
         step_ff <= 1'b0;
      end
   end

   uvp_delay_timer #(.DLY_W(12)) u_alm_timer
   (
      .pclk(pclk),
      .presetn(presetn),
      .cond(alm_below),
      .step(step_ff),
      .delay(alm_dly_ff),
      .operate(alm_op)
   ); // R10

   uvp_delay_timer #(.DLY_W(12)) u_trp_timer
   (
      .pclk(pclk),
      .presetn(presetn),
      .cond(trp_below),
      .step(step_ff),
      .delay(trp_dly_ff),
      .operate(trp_op)
   ); // R10

   // Latches, operate wins over reset command
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alm_latch_ff <= 1'b0;
         trp_latch_ff <= 1'b0;
      end
      else
      begin
         alm_latch_ff <= (alm_mode_ff == UVP_MODE_LATCHED) &&
                         (alm_op || (alm_latch_ff && !reset_cmd)); // R18
         trp_latch_ff <= (trp_mode_ff == UVP_MODE_LATCHED) &&
                         (trp_op || (trp_latch_ff && !reset_cmd)); // R18
      end
   end

   assign alm_out = mode_output(alm_mode_ff, alm_op, alm_latch_ff);
   assign trp_out = mode_output(trp_mode_ff, trp_op, trp_latch_ff);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         relays_ff <= '0;
      end
      else
      begin
         relays_ff.alarm_relay <= alm_out && alm_rly_ff[0]; // R2
         relays_ff.trip_relay <= trp_out && trp_rly_ff[0]; // R3
         relays_ff.auxiliary_relay_one <= (alm_out && alm_rly_ff[1]) ||
                                          (trp_out && trp_rly_ff[1]); // R2 R3
         relays_ff.auxiliary_relay_two <= (alm_out && alm_rly_ff[2]) ||
                                          (trp_out && trp_rly_ff[2]); // R2 R3
      end
   end

   assign relays = relays_ff;

   // Operate edges, event log and interrupts
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alm_prev_ff <= 1'b0;
         trp_prev_ff <= 1'b0;
         log_ff <= 1'b0;
      end
      else
      begin
         alm_prev_ff <= alm_op;
         trp_prev_ff <= trp_op;
         log_ff <= alm_op && !alm_prev_ff && alm_evt_ff; // R8
      end
   end

   assign event_log_strobe = log_ff;
   assign irq_evt[UVP_IRQ_ALM_POS] = alm_op && !alm_prev_ff;
   assign irq_evt[UVP_IRQ_TRP_POS] = trp_op && !trp_prev_ff;
   assign irq_evt[UVP_IRQ_LOG_POS] = log_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_ff <= '0;
         irq_mask_ff <= '0;
      end
      else
      begin
         if (wr_en && (paddr == UVP_IRQ_STAT_OFS))
         begin
            irq_stat_ff <= (irq_stat_ff & ~pwdata[UVP_IRQ_W-1:0]) | irq_evt;
         end
         else
         begin
            irq_stat_ff <= irq_stat_ff | irq_evt;
         end
         if (wr_en && (paddr == UVP_IRQ_MASK_OFS))
         begin
            irq_mask_ff <= pwdata[UVP_IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);
endmodule : uvp_top

// ===== verification/uvp_top_asserts.sv
// Port checks for the undervoltage protection element
`timescale 1ns/1ps
module uvp_top_asserts
   import uvp_pkg::*;
#(
   parameter int STEP_CYCLES = UVP_STEP_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire uvp_relay_s relays,
   input wire logic event_log_strobe,
   input wire logic irq
);
   logic [15:0] ctl_ff;
   logic [2:0] msk_ff;
   logic acc;
   logic bad;
   assign acc = psel && penable;
   assign bad = (paddr > 8'h1C) || (paddr[1:0] != 2'h0);
   // Shadow copies of control and mask
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctl_ff <= 16'h0110;
      else if (acc && pwrite && paddr == UVP_CTRL_OFS)
         ctl_ff <= pwdata[15:0];
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         msk_ff <= 3'h0;
      else if (acc && pwrite && paddr == UVP_IRQ_MASK_OFS)
         msk_ff <= pwdata[2:0];
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_bus_error: assert property (pslverr == (acc && bad))
      else $error("pslverr does not follow the address map");
   a_unmapped_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
      else $error("unmapped read gave data");
   a_alarm_route: assert property (relays.alarm_relay |-> $past(ctl_ff[4]))
      else $error("alarm relay set without routing");
   a_trip_route: assert property (relays.trip_relay |-> $past(ctl_ff[8]))
      else $error("trip relay set without routing");
   a_aux_one_route: assert property (relays.auxiliary_relay_one |->
      $past(ctl_ff[5]) || $past(ctl_ff[9]))
      else $error("auxiliary one set without routing");
   a_aux_two_route: assert property (relays.auxiliary_relay_two |->
      $past(ctl_ff[6]) || $past(ctl_ff[10]))
      else $error("auxiliary two set without routing");
   a_modes_off: assert property ((ctl_ff[3:0] == 4'h0) [*4] |-> relays == 4'h0)
      else $error("relay active with both modes off");
   a_no_wiring: assert property ((ctl_ff[15:14] == 2'h0) [*4] |-> relays == 4'h0)
      else $error("relay active with wiring none");
   a_log_enable: assert property (event_log_strobe |-> $past(ctl_ff[13]))
      else $error("event logged while logging off");
   a_log_pulse: assert property (event_log_strobe |=> !event_log_strobe)
      else $error("event strobe longer than one cycle");
   a_mask_irq: assert property (msk_ff == 3'h0 |-> !irq)
      else $error("irq raised with all sources masked");
endmodule : uvp_top_asserts

bind uvp_top uvp_top_asserts #(.STEP_CYCLES(STEP_CYCLES)) chk_u
(
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pslverr(pslverr),
   .relays(relays),
   .event_log_strobe(event_log_strobe),
   .irq(irq)
);

// ===== verification/uvp_top_tb_top.sv
// Self-checking bench for the undervoltage protection element
`timescale 1ns/1ps
module uvp_top_tb_top;
   import uvp_pkg::*;
   localparam logic [31:0] CTL = 32'h0000_6356;
   localparam logic [15:0] NOM = 16'h03E8;
   localparam uvp_volt_s V_OK = {NOM, NOM, NOM};
   localparam uvp_volt_s V_ALM = {NOM, NOM, 16'h0348};
   localparam uvp_volt_s V_TRP = {16'h02BC, NOM, NOM};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   uvp_volt_s line_volts = V_OK;
   logic [15:0] rated_voltage = NOM;
   logic phase_current_present = 1'b1;
   logic starter_closed = 1'b1;
   logic motor_starting = 1'b0;
   logic voltage_option_fitted = 1'b1;
   uvp_relay_s relays;
   logic event_log_strobe;
   logic irq;
   int n_mismatch = 0;
   int num_checks = 0;
   int n_evt = 0;
   int n;
   logic [31:0] q;
   logic e;
   always #4 pclk = ~pclk;
   always @(posedge pclk)
   begin
      if (event_log_strobe === 1'b1)
         n_evt++;
   end
   uvp_top #(.STEP_CYCLES(4)) dut_u
   (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .line_volts(line_volts),
      .rated_voltage(rated_voltage),
      .phase_current_present(phase_current_present),
      .starter_closed(starter_closed),
      .motor_starting(motor_starting),
      .voltage_option_fitted(voltage_option_fitted),
      .relays(relays),
      .event_log_strobe(event_log_strobe),
      .irq(irq)
   );
   task automatic results();
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1)
      begin
         n_mismatch++;
         results();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask : rd
   task automatic rl(input logic [3:0] x);
      repeat (3) @(posedge pclk);
      chk({28'h0, relays}, {28'h0, x});
   endtask : rl
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(UVP_CTRL_OFS, 32'h0000_0110);
      rd(UVP_ALM_PU_OFS, 32'h0000_5555);
      rd(UVP_DELAY_OFS, 32'h000A_001E);
      apb(1'b0, 8'h22, 32'h0);
      chk({q[30:0], e}, 32'h1);
      apb(1'b1, UVP_ALM_PU_OFS, 32'h0000_6431);
      rd(UVP_ALM_PU_OFS, 32'h0000_6332);
      apb(1'b1, UVP_DELAY_OFS, 32'h0FFF_0000);
      rd(UVP_DELAY_OFS, 32'h09F6_0000);
      apb(1'b1, UVP_ALM_PU_OFS, 32'h0000_553C);
      apb(1'b1, UVP_TRP_PU_OFS, 32'h0000_5032);
      apb(1'b1, UVP_DELAY_OFS, 32'h0002_0000);
      apb(1'b1, UVP_CTRL_OFS, CTL);
      rl(4'h0);
      line_volts <= V_ALM;
      rl(4'h9);
      chk(n_evt, 1);
      chk({31'h0, irq}, 32'h0);
      rd(UVP_IRQ_STAT_OFS, 32'h5);
      apb(1'b1, UVP_IRQ_MASK_OFS, 32'h1);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, UVP_IRQ_STAT_OFS, 32'h5);
      rd(UVP_IRQ_STAT_OFS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      line_volts <= V_OK;
      rl(4'h0);
      motor_starting <= 1'b1;
      line_volts <= V_ALM;
      rl(4'h0);
      motor_starting <= 1'b0;
      rl(4'h9);
      rated_voltage <= 16'h0384;
      rl(4'h0);
      rated_voltage <= NOM;
      line_volts <= V_TRP;
      n = 0;
      while (relays.trip_relay !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n >= 4 && n <= 12), 32'h1);
      rl(4'hF);
      line_volts <= V_OK;
      rl(4'h6);
      apb(1'b1, UVP_RESET_OFS, 32'h1);
      rl(4'h0);
      repeat (3)
      begin
         line_volts <= V_TRP;
         repeat (3) @(posedge pclk);
         line_volts <= V_OK;
         repeat (2) @(posedge pclk);
      end
      rl(4'h0);
      phase_current_present <= 1'b0;
      starter_closed <= 1'b0;
      line_volts <= V_ALM;
      rl(4'h0);
      starter_closed <= 1'b1;
      rl(4'h9);
      starter_closed <= 1'b0;
      apb(1'b1, UVP_CTRL_OFS, CTL | 32'h1000);
      rl(4'h9);
      line_volts <= V_TRP;
      repeat (12) @(posedge pclk);
      rl(4'hF);
      rd(UVP_STATUS_OFS, 32'h0000_001B);
      phase_current_present <= 1'b1;
      starter_closed <= 1'b1;
      apb(1'b1, UVP_RESET_OFS, 32'h1);
      rl(4'hF);
      line_volts <= V_ALM;
      apb(1'b1, UVP_RESET_OFS, 32'h1);
      voltage_option_fitted <= 1'b0;
      rl(4'h0);
      voltage_option_fitted <= 1'b1;
      rl(4'h9);
      apb(1'b1, UVP_CTRL_OFS, 32'h0000_2356);
      rl(4'h0);
      apb(1'b1, UVP_CTRL_OFS, 32'h0000_A356);
      rl(4'h9);
      apb(1'b1, UVP_CTRL_OFS, 32'h0000_A357);
      rd(UVP_CTRL_OFS, 32'h0000_A354);
      rl(4'h0);
      results();
   end
endmodule : uvp_top_tb_top
